// *** ecp_pkg.sv ***
// Shared constants and types for the external control port
package ecp_pkg;

  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned NUM_CH  = 4;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFF_EVENT    = 8'h10;
  localparam logic [7:0] OFF_JUDGE    = 8'h14;
  localparam logic [7:0] OFF_CHECK    = 8'h18;

  // Field positions
  localparam int unsigned CTRL_EXT_ACQUIRE_PULSE = 0;
  localparam int unsigned EV_ACQ_DONE   = 0;
  localparam int unsigned EV_JUDGE_DONE = 1;
  localparam int unsigned JUDGE_HI_LSB  = 0;
  localparam int unsigned JUDGE_IN_LSB  = 4;
  localparam int unsigned JUDGE_LO_LSB  = 8;
  localparam int unsigned CHECK_GO_LSB  = 0;
  localparam int unsigned CHECK_OPEN    = 4;
  localparam int unsigned CHECK_ERR     = 5;
  localparam int unsigned STAT_VALID    = 4;
  localparam int unsigned STAT_LOCK     = 5;
  localparam int unsigned STAT_HALT     = 6;

  // Pin input indices
  localparam int unsigned IN_ACQUIRE_PULSE   = 0;
  localparam int unsigned IN_CHECK  = 1;
  localparam int unsigned IN_OPEN   = 2;
  localparam int unsigned IN_START  = 3;
  localparam int unsigned IN_STOP   = 4;
  localparam int unsigned IN_WIPE   = 5;
  localparam int unsigned IN_FREEZE = 6;
  localparam int unsigned NUM_IN    = 7;

  // Interrupt bits: 0..5 follow input indices, then done
  localparam int unsigned IRQ_DONE = 6;
  localparam int unsigned IRQ_W    = 7;

  // Reset values
  localparam logic       RST_EXT_ACQUIRE_PULSE = 1'b0;
  localparam logic       RST_DONE     = 1'b1;
  localparam logic [6:0] RST_MASK     = 7'h00;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ARMED = 4'b0010,
    ST_MEAS  = 4'b0100,
    ST_JUDGE = 4'b1000
  } meas_state_t;

endpackage

// *** edge_sync.sv ***
// Two-flop synchroniser with rising-edge pulse per input
`timescale 1ns/1ps
module edge_sync #(
  parameter int unsigned W = 7
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sync_t;

  sync_t cur;
  sync_t next_cur;

  always_comb begin
    next_cur    = cur;
    next_cur.s1 = raw;
    next_cur.s2 = cur.s1;
    next_cur.s3 = cur.s2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign level = cur.s2;
  // Only stages two and three are compared; stage one may be metastable
  assign rise  = cur.s2 & ~cur.s3;

  a_rise_single: assert property (@(posedge pclk) disable iff (!presetn)
    |rise |=> ((rise & $past(rise)) == '0))
    else $error("edge pulse lasted more than one cycle");
endmodule

// *** external_control_port.sv ***
// Isolated external control port: pin commands, judgment outputs, APB registers
`timescale 1ns/1ps
// What this block does
// - Done and conversion flags on at reset
// - Wipe acts once per input edge
// - Key lock follows freeze input level
// - Open correction request sets an interrupt bit on each edge
// - Check, trigger, start, stop are edge commands
// - Four channels of held judgment outputs
// - Contact pass, open pass, error outputs
// - Done flag only after measure and judgment
// - Start measures internal, arms under external
// - Stop halts, or aborts without update
// - Wipe only when idle or armed, then no result
module external_control_port #(
  parameter int unsigned CH = ecp_pkg::NUM_CH
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [ecp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [ecp_pkg::DATA_W-1:0] pwdata,
  output logic      [ecp_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       acquire_pulse,
  input  wire logic                       contact_check_request,
  input  wire logic                       open_correct_request,
  input  wire logic                       start_request,
  input  wire logic                       stop_request,
  input  wire logic                       result_wipe_request,
  input  wire logic                       panel_freeze_request,
  output logic                            measure_done_flag,
  output logic                            conversion_done_flag,
  output logic                            error_flag,
  output logic                            open_pass_flag,
  output logic      [CH-1:0]              contact_pass_flag,
  output logic      [CH-1:0]              above_upper_limit_flag,
  output logic      [CH-1:0]              pass_band_flag,
  output logic      [CH-1:0]              under_bottom_limit_flag,
  output logic                            panel_locked,
  output logic                            irq
);
  import ecp_pkg::*;

  typedef struct packed {
    meas_state_t       state;
    logic              ext_acquire_pulse;
    logic              halt;
    logic              conv_done;
    logic              meas_done;
    logic              err;
    logic              open_go;
    logic [CH-1:0]     contact;
    logic [CH-1:0]     hi;
    logic [CH-1:0]     inb;
    logic [CH-1:0]     lo;
    logic [CH-1:0]     stage_hi;
    logic [CH-1:0]     stage_in;
    logic [CH-1:0]     stage_lo;
    logic              valid;
    logic              locked;
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } port_state_t;

  port_state_t cur;
  port_state_t next_cur;

  logic [NUM_IN-1:0] pin_level;
  logic [NUM_IN-1:0] pin_rise;
  logic [IRQ_W-1:0]  irq_status;
  logic [IRQ_W-1:0]  irq_mask;
  logic [IRQ_W-1:0]  irq_set;
  logic              done_ev;
  logic              wr_fire;
  logic              clr_we;
  logic              mask_we;

  edge_sync #(.W(NUM_IN)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     ({panel_freeze_request, result_wipe_request, stop_request, start_request,
                open_correct_request, contact_check_request, acquire_pulse}),
    .level   (pin_level),
    .rise    (pin_rise)
  );

  // Command edges are handed to firmware as sticky interrupt bits
  assign irq_set = {done_ev, pin_rise[IN_WIPE:IN_ACQUIRE_PULSE]};
  assign clr_we  = wr_fire && (paddr == OFF_IRQ_STAT);
  assign mask_we = wr_fire && (paddr == OFF_IRQ_MASK);

  irq_unit #(.W(IRQ_W)) u_irq (
    .pclk      (pclk),
    .presetn   (presetn),
    .set       (irq_set),
    .clr_we    (clr_we),
    .clr_data  (pwdata[IRQ_W-1:0]),
    .mask_we   (mask_we),
    .mask_data (pwdata[IRQ_W-1:0]),
    .status    (irq_status),
    .mask      (irq_mask),
    .irq       (irq)
  );

  assign wr_fire = psel && penable && cur.pready && pwrite;

  always_comb begin
    logic              start_ev;
    logic              stop_ev;
    logic              acquire_pulse_ev;
    logic              wipe_ev;
    logic              acq_ev;
    logic              judge_ev;
    logic              hit;
    logic [DATA_W-1:0] rd_val;
    start_ev = pin_rise[IN_START];
    stop_ev  = pin_rise[IN_STOP];
    acquire_pulse_ev  = pin_rise[IN_ACQUIRE_PULSE];
    wipe_ev  = pin_rise[IN_WIPE];
    acq_ev   = wr_fire && (paddr == OFF_EVENT) && pwdata[EV_ACQ_DONE];
    judge_ev = wr_fire && (paddr == OFF_EVENT) && pwdata[EV_JUDGE_DONE];
    hit      = 1'b1;
    rd_val   = '0;
    done_ev  = 1'b0;
    next_cur = cur;

    // Register read decode
    if (paddr == OFF_CTRL) begin
      rd_val[CTRL_EXT_ACQUIRE_PULSE] = cur.ext_acquire_pulse;
    end else if (paddr == OFF_STATUS) begin
      rd_val[3:0]        = cur.state;
      rd_val[STAT_VALID] = cur.valid;
      rd_val[STAT_LOCK]  = cur.locked;
      rd_val[STAT_HALT]  = cur.halt;
    end else if (paddr == OFF_IRQ_STAT) begin
      rd_val[IRQ_W-1:0] = irq_status;
    end else if (paddr == OFF_IRQ_MASK) begin
      rd_val[IRQ_W-1:0] = irq_mask;
    end else if (paddr == OFF_EVENT) begin
      rd_val = '0;
    end else if (paddr == OFF_JUDGE) begin
      rd_val[JUDGE_HI_LSB +: CH] = cur.stage_hi;
      rd_val[JUDGE_IN_LSB +: CH] = cur.stage_in;
      rd_val[JUDGE_LO_LSB +: CH] = cur.stage_lo;
    end else if (paddr == OFF_CHECK) begin
      rd_val[CHECK_GO_LSB +: CH] = cur.contact;
      rd_val[CHECK_OPEN]         = cur.open_go;
      rd_val[CHECK_ERR]          = cur.err;
    end else begin
      hit = 1'b0;
    end

    // One wait state: ready answers in the second access cycle
    next_cur.pready  = psel && penable && !cur.pready;
    next_cur.pslverr = psel && penable && !cur.pready && !hit;
    if (psel && penable && !cur.pready && !pwrite) begin
      next_cur.prdata = rd_val;
    end

    // Register writes
    if (wr_fire) begin
      if (paddr == OFF_CTRL) begin
        next_cur.ext_acquire_pulse = pwdata[CTRL_EXT_ACQUIRE_PULSE];
      end else if (paddr == OFF_JUDGE) begin
        next_cur.stage_hi = pwdata[JUDGE_HI_LSB +: CH];
        next_cur.stage_in = pwdata[JUDGE_IN_LSB +: CH];
        next_cur.stage_lo = pwdata[JUDGE_LO_LSB +: CH];
      end else if (paddr == OFF_CHECK) begin
        next_cur.contact = pwdata[CHECK_GO_LSB +: CH];
        next_cur.open_go = pwdata[CHECK_OPEN];
        next_cur.err     = pwdata[CHECK_ERR];
      end
    end

    next_cur.locked = pin_level[IN_FREEZE];

    case (cur.state)
      ST_IDLE: begin
        if (start_ev) begin
          next_cur.state = cur.ext_acquire_pulse ? ST_ARMED : ST_MEAS;
        end
      end
      ST_ARMED: begin
        if (stop_ev) begin
          next_cur.state = ST_IDLE;
        end else if (acquire_pulse_ev) begin
          next_cur.state = ST_MEAS;
        end
      end
      ST_MEAS: begin
        // In internal mode, done flags from the last judgment stand one cycle here, then drop
        next_cur.conv_done = 1'b0;
        next_cur.meas_done = 1'b0;
        if (stop_ev) begin
          next_cur.state = ST_IDLE;
        end else if (acq_ev) begin
          next_cur.conv_done = 1'b1;
          next_cur.state     = ST_JUDGE;
        end
      end
      ST_JUDGE: begin
        if (stop_ev && cur.ext_acquire_pulse) begin
          next_cur.state = ST_IDLE;
        end else if (judge_ev) begin
          // Judgment outputs move only here or on a wipe, so all three flags change together
          next_cur.hi        = cur.stage_hi;
          next_cur.inb       = cur.stage_in;
          next_cur.lo        = cur.stage_lo;
          next_cur.valid     = 1'b1;
          next_cur.meas_done = 1'b1;
          done_ev            = 1'b1;
          if (cur.halt || stop_ev) begin
            next_cur.state = ST_IDLE;
          end else begin
            next_cur.state = cur.ext_acquire_pulse ? ST_ARMED : ST_MEAS;
          end
        end else if (stop_ev) begin
          // Internal mode lets the running judgment finish first
          next_cur.halt = 1'b1;
        end
      end
      default: begin
        next_cur.state = ST_IDLE;
      end
    endcase

    if (next_cur.state != ST_JUDGE) begin
      next_cur.halt = 1'b0;
    end
    if (next_cur.state == ST_MEAS && cur.state != ST_MEAS && cur.state != ST_JUDGE) begin
      next_cur.conv_done = 1'b0;
      next_cur.meas_done = 1'b0;
    end

    // Wipe is ignored while a measurement runs
    if (wipe_ev && (cur.state == ST_IDLE || cur.state == ST_ARMED)) begin
      next_cur.hi    = '0;
      next_cur.inb   = '0;
      next_cur.lo    = '0;
      next_cur.valid = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur           <= '0;
      cur.state     <= ST_IDLE;
      cur.ext_acquire_pulse  <= RST_EXT_ACQUIRE_PULSE;
      cur.conv_done <= RST_DONE;
      cur.meas_done <= RST_DONE;
    end else begin
      cur <= next_cur;
    end
  end

  assign prdata                  = cur.prdata;
  assign pready                  = cur.pready;
  assign pslverr                 = cur.pslverr;
  assign measure_done_flag       = cur.meas_done;
  assign conversion_done_flag    = cur.conv_done;
  assign error_flag              = cur.err;
  assign open_pass_flag          = cur.open_go;
  assign contact_pass_flag       = cur.contact;
  assign above_upper_limit_flag  = cur.hi;
  assign pass_band_flag          = cur.inb;
  assign under_bottom_limit_flag = cur.lo;
  assign panel_locked            = cur.locked;

  a_done_fall_meas: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(measure_done_flag) || $fell(conversion_done_flag)
    |-> (cur.state == ST_MEAS || $past(cur.state) == ST_MEAS))
    else $error("done flag dropped outside a new measurement");

  a_done_after_judge: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(measure_done_flag) |-> $past(cur.state) == ST_JUDGE && conversion_done_flag)
    else $error("done flag rose before judgment");

  a_wipe_clears: assert property (@(posedge pclk) disable iff (!presetn)
    pin_rise[IN_WIPE] && cur.state == ST_IDLE
    |=> above_upper_limit_flag == '0 && pass_band_flag == '0 && !cur.valid)
    else $error("wipe did not clear result");

  a_wipe_busy: assert property (@(posedge pclk) disable iff (!presetn)
    pin_rise[IN_WIPE] && cur.state == ST_MEAS |=> $stable(under_bottom_limit_flag))
    else $error("wipe acted during a measurement");

  a_lock_level: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 panel_locked == $past(pin_level[IN_FREEZE]))
    else $error("key lock does not follow freeze level");

  a_open_edge: assert property (@(posedge pclk) disable iff (!presetn)
    pin_rise[IN_OPEN] |=> irq_status[IN_OPEN])
    else $error("open correction request not flagged");

  a_start_mode: assert property (@(posedge pclk) disable iff (!presetn)
    pin_rise[IN_START] && !pin_rise[IN_STOP] && cur.state == ST_IDLE
    |=> cur.state == ($past(cur.ext_acquire_pulse) ? ST_ARMED : ST_MEAS))
    else $error("start edge gave wrong state");

  a_stop_abort: assert property (@(posedge pclk) disable iff (!presetn)
    pin_rise[IN_STOP] && cur.ext_acquire_pulse && cur.state == ST_JUDGE
    |=> cur.state == ST_IDLE && $stable(pass_band_flag))
    else $error("external stop updated the result");

  a_judge_held: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(above_upper_limit_flag) |-> $past(cur.state) == ST_JUDGE || $past(pin_rise[IN_WIPE]))
    else $error("judgment output changed without cause");

  a_acquire_pulse_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    pin_rise[IN_ACQUIRE_PULSE] && cur.state == ST_IDLE && !pin_rise[IN_START] |=> cur.state == ST_IDLE)
    else $error("trigger accepted before start");

  c_ext_cycle: cover property (@(posedge pclk) disable iff (!presetn)
    cur.state == ST_ARMED ##1 cur.state == ST_MEAS);
  c_done: cover property (@(posedge pclk) disable iff (!presetn) $rose(measure_done_flag));
  c_wipe: cover property (@(posedge pclk) disable iff (!presetn)
    pin_rise[IN_WIPE] && cur.valid && cur.state == ST_IDLE);
  c_abort: cover property (@(posedge pclk) disable iff (!presetn)
    pin_rise[IN_STOP] && cur.state == ST_JUDGE);
endmodule

// *** irq_unit.sv ***
// Sticky interrupt status with mask and level output
`timescale 1ns/1ps
module irq_unit #(
  parameter int unsigned W = 7
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] set,
  input  wire logic         clr_we,
  input  wire logic [W-1:0] clr_data,
  input  wire logic         mask_we,
  input  wire logic [W-1:0] mask_data,
  output logic      [W-1:0] status,
  output logic      [W-1:0] mask,
  output logic              irq
);
  import ecp_pkg::*;

  typedef struct packed {
    logic [W-1:0] status;
    logic [W-1:0] mask;
    logic         irq;
  } irq_state_t;

  irq_state_t cur;
  irq_state_t next_cur;

  always_comb begin
    next_cur = cur;
    // Set beats a simultaneous write-one-to-clear
    next_cur.status = (cur.status & ~(clr_we ? clr_data : '0)) | set;
    if (mask_we) begin
      next_cur.mask = mask_data;
    end
    next_cur.irq = |(next_cur.status & next_cur.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur      <= '0;
      cur.mask <= W'(RST_MASK);
    end else begin
      cur <= next_cur;
    end
  end

  assign status = cur.status;
  assign mask   = cur.mask;
  assign irq    = cur.irq;

  a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (set != '0) |=> ((status & $past(set)) == $past(set)))
    else $error("event lost against clear");
endmodule

// *** plc_model.sv ***
// Controller model that pulses the command pins of the port
`timescale 1ns/1ps
module plc_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       go,
  input  wire logic [2:0] sel,
  input  wire logic [3:0] len,
  input  wire logic [3:0] hi,
  input  wire logic [3:0] mid,
  input  wire logic [3:0] lo,
  output logic      [5:0] pins,
  output logic            busy,
  output logic      [1:0] verdict
);
  logic [4:0] cnt;

  // High for len cycles, then low four (len 0 leaves the pin high): the port needs one each way
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins <= '0;
      cnt  <= '0;
    end else if (go && cnt == 5'h00) begin
      pins <= 6'h01 << sel;
      cnt  <= {1'b0, len} + 5'h04;
    end else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
      if (cnt == 5'h05) begin
        pins <= '0;
      end
    end
  end

  assign busy = go || (cnt != 5'h00);

  // One outcome only when exactly one of the three channel 0 bits is on
  always_comb begin
    case ({hi[0], mid[0], lo[0]})
      3'b100:  verdict = 2'h1;
      3'b010:  verdict = 2'h2;
      3'b001:  verdict = 2'h3;
      default: verdict = 2'h0;
    endcase
  end
endmodule

// *** tb_external_control_port.sv ***
// Self-checking bench for the external control port
`timescale 1ns/1ps
module tb_external_control_port;
  import ecp_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, mdone, cdone, err_f, open_f, locked, busy;
  logic        go = 1'b0;
  logic        freeze = 1'b0;
  logic [2:0]  sel = 3'h0;
  logic [3:0]  len = 4'h3;
  logic [3:0]  cpass, hi, mid, lo;
  logic [5:0]  pins;
  logic [1:0]  verdict;
  logic [31:0] jv, cv;
  logic [64:0] exp_q[$];
  int          n_errors = 0;
  int          tests_run = 0;

  always #25 pclk = ~pclk;

  external_control_port dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq,
    .acquire_pulse(pins[IN_ACQUIRE_PULSE]),
    .contact_check_request(pins[IN_CHECK]),
    .open_correct_request(pins[IN_OPEN]),
    .start_request(pins[IN_START]),
    .stop_request(pins[IN_STOP]),
    .result_wipe_request(pins[IN_WIPE]),
    .panel_freeze_request(freeze),
    .measure_done_flag(mdone),
    .conversion_done_flag(cdone),
    .error_flag(err_f),
    .open_pass_flag(open_f),
    .contact_pass_flag(cpass),
    .above_upper_limit_flag(hi),
    .pass_band_flag(mid),
    .under_bottom_limit_flag(lo),
    .panel_locked(locked)
  );

  plc_model plc (
    .pclk, .presetn, .go, .sel, .len, .hi, .mid, .lo, .pins, .busy, .verdict
  );

  task automatic final_report();
    if (exp_q.size() != 0) n_errors++;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [64:0] e);
    tests_run++;
    if ({pslverr, prdata & e[63:32]} !== {e[64], e[31:0]}) begin
      n_errors++;
      $display("MISMATCH %0t read %h err %b expected %h", $time, prdata, pslverr, e[31:0]);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Request held until pready, then one idle cycle so psel never toggles twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1,
                    input logic err = 1'b0);
    exp_q.push_back({err, m, e & m});
    apb(1'b0, a, 32'h0);
  endtask

  // Three extra edges cover the pin synchroniser
  task automatic pulse(input int idx, input logic [3:0] w = 4'h3);
    sel <= 3'(idx);
    len <= w;
    go  <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    while (busy === 1'b1) begin
      @(posedge pclk);
    end
    tick(3);
  endtask

  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (exp_q.size() == 0) chk_out(32'h0, 32'h1, "unexpected read");
      else chk_rd(exp_q.pop_front());
    end
  end

  initial begin
    tick(5000);
    n_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    final_report();
  end

  initial begin
    void'($urandom(20));
    jv = $urandom & 32'hfff;
    cv = $urandom & 32'h3f;
    tick(3);
    chk_out({mdone, cdone}, 32'h3, "flags in reset");
    chk_out({hi, mid, lo, cpass, err_f, open_f, locked, irq}, 32'h0, "outputs in reset");
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_CTRL, 32'h0);
    rd(OFF_STATUS, 32'h1, 32'h7f);
    rd(OFF_IRQ_MASK, 32'h0);
    rd(OFF_EVENT, 32'h0);
    rd(8'h1c, 32'h0, '1, 1'b1);
    pulse(IN_CHECK);
    chk_out(irq, 32'h0, "irq while masked");
    rd(OFF_IRQ_STAT, 32'h2, 32'h7f);
    wr(OFF_IRQ_MASK, 32'h7f);
    tick(2);
    chk_out(irq, 32'h1, "irq unmasked");
    wr(OFF_IRQ_STAT, 32'h7f);
    tick(2);
    chk_out(irq, 32'h0, "irq cleared");
    for (int i = 0; i < 6; i++) begin
      pulse(i, 4'h6);
      rd(OFF_IRQ_STAT, 32'h1 << i, 32'h3f);
      wr(OFF_IRQ_STAT, 32'h7f);
    end
    rd(OFF_STATUS, 32'h1, 32'hf);
    // Clear while the pin is still held: a level reading would set it again
    sel <= 3'(IN_OPEN);
    len <= 4'hf;
    go  <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(8);
    wr(OFF_IRQ_STAT, 32'h7f);
    pulse(IN_OPEN, 4'h0);
    rd(OFF_IRQ_STAT, 32'h0, 32'h3f);
    pulse(IN_START);
    chk_out({mdone, cdone}, 32'h0, "flags at start");
    rd(OFF_STATUS, 32'h4, 32'hf);
    wr(OFF_JUDGE, jv);
    wr(OFF_EVENT, 32'h1);
    tick(2);
    chk_out({mdone, cdone, hi, mid, lo}, 32'h1000, "acquired only");
    pulse(IN_WIPE);
    wr(OFF_EVENT, 32'h2);
    tick(2);
    chk_out({lo, mid, hi}, jv[11:0], "judgments");
    rd(OFF_IRQ_STAT, 32'h40, 32'h40);
    pulse(IN_STOP);
    rd(OFF_STATUS, 32'h11, 32'h1f);
    pulse(IN_WIPE);
    rd(OFF_STATUS, 32'h1, 32'h1f);
    chk_out({lo, mid, hi}, 32'h0, "judgments wiped");
    chk_out(verdict, 32'h0, "no outcome when wiped");
    // Internal stop during judgment: the result still lands, then idle
    pulse(IN_START);
    wr(OFF_JUDGE, 32'h421);
    wr(OFF_EVENT, 32'h1);
    pulse(IN_STOP);
    rd(OFF_STATUS, 32'h48, 32'h7f);
    wr(OFF_EVENT, 32'h2);
    tick(2);
    rd(OFF_STATUS, 32'h11, 32'h7f);
    chk_out({mdone, cdone, lo, mid, hi}, 32'h3421, "stop lets judgment finish");
    chk_out(verdict, 32'h1, "upper only outcome");
    wr(OFF_CTRL, 32'h1);
    pulse(IN_ACQUIRE_PULSE);
    rd(OFF_STATUS, 32'h1, 32'hf);
    pulse(IN_START);
    rd(OFF_STATUS, 32'h2, 32'hf);
    pulse(IN_ACQUIRE_PULSE);
    rd(OFF_STATUS, 32'h4, 32'hf);
    wr(OFF_JUDGE, jv);
    wr(OFF_EVENT, 32'h1);
    wr(OFF_EVENT, 32'h2);
    tick(2);
    rd(OFF_STATUS, 32'h2, 32'hf);
    chk_out({mdone, cdone, lo, mid, hi}, {2'b11, jv[11:0]}, "external done");
    pulse(IN_ACQUIRE_PULSE);
    wr(OFF_JUDGE, ~jv & 32'hfff);
    wr(OFF_EVENT, 32'h1);
    pulse(IN_STOP);
    chk_out({lo, mid, hi}, jv[11:0], "abort keeps result");
    freeze <= 1'b1;
    tick(5);
    rd(OFF_STATUS, 32'h20, 32'h20);
    tick(20);
    chk_out(locked, 32'h1, "lock held");
    freeze <= 1'b0;
    tick(5);
    chk_out(locked, 32'h0, "lock released");
    wr(OFF_CHECK, cv);
    tick(2);
    chk_out({err_f, open_f, cpass}, cv[5:0], "check outputs");
    rd(OFF_CHECK, cv, 32'h3f);
    tick(3);
    final_report();
  end
endmodule
